// File: rtl/tcx_consts.svh
`ifndef TCX_CONSTS_SVH
`define TCX_CONSTS_SVH
// register bus geometry
`define TCX_ADDR_W 8
`define TCX_DATA_W 32
`define TCX_BYTE_PAD 24'h000000
// byte addresses of the registers
`define TCX_OFS_STATUS 8'h00
`define TCX_OFS_MASK 8'h04
`define TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL 8'h88
`define TCX_OFS_TIMER_TWO_CONTROL 8'hc8
// bus answers
`define TCX_RESP_OKAY 2'h0
`define TCX_RESP_SLVERR 2'h2
// reset values
`define TCX_RST_BIT 1'h0
`define TCX_RST_EVT 6'h00
`define TCX_RST_BYTE 8'h00
`define TCX_PIN_IDLE 1'h1
// timer 0/1 and ext interrupt control layout
`define TCX_TC_TF1 7
`define TCX_TC_TR1 6
`define TCX_TC_TF0 5
`define TCX_TC_TR0 4
`define TCX_TC_IT1 2
`define TCX_TC_IT0 0
// timer 2 control layout
`define TCX_T2_TF2 7
`define TCX_T2_TIMER_TWO_EXTERNAL_FLAG 6
`define TCX_T2_RCLK 5
`define TCX_T2_SERIAL_TX_CLOCK_SELECT 4
`define TCX_T2_EXEN 3
`define TCX_T2_TR2 2
`define TCX_T2_CT 1
`define TCX_T2_CPRL 0
// event bits in status and mask
`define TCX_EVT_W 6
`define TCX_EV_TF0 0
`define TCX_EV_TF1 1
`define TCX_EV_IE0 2
`define TCX_EV_IE1 3
`define TCX_EV_TF2 4
`define TCX_EV_TIMER_TWO_EXTERNAL_FLAG 5
// external interrupt channels
`define TCX_EXT_N 2
// serial modes that take a timer clock
`define TCX_UART_MODE1 2'h1
`define TCX_UART_MODE3 2'h3
`endif

// File: rtl/tcx_pkg.sv
package tcx_pkg;
  // trigger type of an external interrupt input
  typedef enum logic {TCX_TRIG_LEVEL, TCX_TRIG_FALL} tcx_trig_t;
  // serial port mode number
  typedef logic [1:0] tcx_uart_mode_t;
  // one register byte
  typedef logic [7:0] tcx_byte_t;
endpackage

// File: rtl/tcx_ext_if.sv
`timescale 1ns/1ps
`include "tcx_consts.svh"
interface tcx_ext_if;
  logic [`TCX_EXT_N-1:0] pin_n; // external interrupt pins, low active
  logic [`TCX_EXT_N-1:0] trig_type; // one = falling edge
  logic [`TCX_EXT_N-1:0] vec_ack; // processor vectors to the routine
  logic [`TCX_EXT_N-1:0] flag; // edge flags
  logic [`TCX_EXT_N-1:0] set_evt; // flag rises next edge
  modport ctrl (output pin_n, output trig_type, output vec_ack, input flag, input set_evt);
  modport unit (input pin_n, input trig_type, input vec_ack, output flag, output set_evt);
endinterface

// File: rtl/tcx_ext_int.sv
`timescale 1ns/1ps
`include "tcx_consts.svh"
module tcx_ext_int (
  input wire logic aclk,
  input wire logic aresetn,
  tcx_ext_if.unit ext
);
  import tcx_pkg::*;

  logic [`TCX_EXT_N-1:0] flag_q; // edge flags
  logic [`TCX_EXT_N-1:0] pin_d; // pins one cycle ago
  wire [`TCX_EXT_N-1:0] next_flag; // flag value for next edge

  // per channel: edge mode latches a fall, level mode tracks the pin
  for (genvar i = 0; i < `TCX_EXT_N; i++) begin : g_ch
    wire fall; // high to low seen this cycle
    assign fall = pin_d[i] && !ext.pin_n[i];
    // set beats the clear from vectoring
    assign next_flag[i] = (ext.trig_type[i] == TCX_TRIG_FALL) ?
      ((flag_q[i] && !ext.vec_ack[i]) || fall) : !ext.pin_n[i];

    a_edge_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (ext.trig_type[i] && pin_d[i] && !ext.pin_n[i]) |=> flag_q[i])
      else $error("falling edge did not set the edge flag");
    a_ack_clears_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (ext.trig_type[i] && ext.vec_ack[i] && !fall) |=> !flag_q[i])
      else $error("vectoring did not clear the edge flag");
    a_level_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      (!ext.trig_type[i]) |=> (flag_q[i] == !$past(ext.pin_n[i])))
      else $error("level mode flag does not follow the pin");
  end

  // flag and pin history registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= '0;
      pin_d <= '1;
    end else begin
      flag_q <= next_flag;
      pin_d <= ext.pin_n;
    end
  end

  assign ext.flag = flag_q;
  assign ext.set_evt = next_flag & ~flag_q;
endmodule

// File: rtl/tcx_timer_ctrl.sv
`timescale 1ns/1ps
`include "tcx_consts.svh"
module tcx_timer_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [`TCX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`TCX_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TCX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`TCX_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // counting datapaths
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic machine_cycle_tick,
  input wire logic timer2_count_pin,
  input wire logic capture_reload_pin,
  input wire logic ext_int0_pin_n,
  input wire logic ext_int1_pin_n,
  // processor vectoring
  input wire logic vec_ack_timer0,
  input wire logic vec_ack_timer1,
  input wire logic vec_ack_ext0,
  input wire logic vec_ack_ext1,
  // serial port
  input wire tcx_pkg::tcx_uart_mode_t uart_mode,
  output logic serial_rx_clk,
  output logic serial_tx_clk,
  // timer control outputs
  output logic timer0_count_en,
  output logic timer1_count_en,
  output logic timer2_count_tick,
  output logic timer2_count_source,
  output logic timer2_capture,
  output logic timer2_reload,
  // interrupt requests
  output logic timer0_irq_req,
  output logic timer1_irq_req,
  output logic ext_int0_irq_req,
  output logic ext_int1_irq_req,
  output logic timer2_irq_req,
  output logic irq
);
  import tcx_pkg::*;

  // bus slave state
  logic aw_hold; // write address taken, not yet used
  logic w_hold; // write data taken, not yet used
  logic [`TCX_ADDR_W-1:0] aw_addr; // held write address
  logic [`TCX_DATA_W-1:0] w_data; // held write data
  logic [3:0] w_strb; // held byte enables
  logic wr_fire; // write executes this edge
  logic wr_lane; // low byte lane enabled
  logic wr_hit; // held address is mapped
  logic wr_timer01_ext_interrupt_control; // write to timer 0/1 control
  logic wr_t2; // write to timer 2 control
  logic wr_status; // write-one-to-clear of status
  logic wr_mask; // write of mask

  // timer 0/1 control fields
  logic tf1, tr1, tf0, tr0, it1, it0;
  // timer 2 control fields
  logic tf2, timer_two_external_flag, rclk, serial_tx_clock_select, timer_two_ext_enable, tr2, ct2, cprl2;
  // interrupt status and mask
  logic [`TCX_EVT_W-1:0] status;
  logic [`TCX_EVT_W-1:0] mask;
  logic [`TCX_EVT_W-1:0] evt; // one-cycle event pulses

  // timer 2 pin history and decode
  logic capture_reload_pin_d; // capture/reload pin one cycle ago
  logic cnt_d; // count pin one cycle ago
  logic baud; // timer 2 clocks the serial port
  logic ext_event; // qualified capture/reload pin edge
  logic tf2_set; // overflow that may set the flag
  logic mode13; // serial mode takes a timer clock
  logic next_capture, next_reload, next_count, next_rx, next_tx;
  tcx_byte_t rd_byte; // read mux result
  logic rd_hit; // read address is mapped

  tcx_ext_if ext_bus ();

  tcx_ext_int u_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext(ext_bus)
  );

  // external interrupt channel hookup
  assign ext_bus.pin_n = {ext_int1_pin_n, ext_int0_pin_n};
  assign ext_bus.trig_type = {it1, it0};
  assign ext_bus.vec_ack = {vec_ack_ext1, vec_ack_ext0};

  // bus handshakes: one write and one read in flight
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_lane = wr_fire && w_strb[0];
  assign wr_timer01_ext_interrupt_control = wr_lane && (aw_addr == `TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL);
  assign wr_t2 = wr_lane && (aw_addr == `TCX_OFS_TIMER_TWO_CONTROL);
  assign wr_status = wr_lane && (aw_addr == `TCX_OFS_STATUS);
  assign wr_mask = wr_lane && (aw_addr == `TCX_OFS_MASK);
  assign wr_hit = (aw_addr == `TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL) || (aw_addr == `TCX_OFS_TIMER_TWO_CONTROL) ||
    (aw_addr == `TCX_OFS_STATUS) || (aw_addr == `TCX_OFS_MASK);

  // write channel: hold address and data, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= `TCX_RST_BIT;
      w_hold <= `TCX_RST_BIT;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= `TCX_RST_BIT;
      s_axi_bresp <= `TCX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // both halves used, response goes out
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TCX_RESP_OKAY : `TCX_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // response taken
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux over the mapped registers
  always_comb begin
    rd_byte = `TCX_RST_BYTE;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL: begin
        rd_byte = {tf1, tr1, tf0, tr0, ext_bus.flag[1], it1, ext_bus.flag[0], it0};
      end
      `TCX_OFS_TIMER_TWO_CONTROL: begin
        rd_byte = {tf2, timer_two_external_flag, rclk, serial_tx_clock_select, timer_two_ext_enable, tr2, ct2, cprl2};
      end
      `TCX_OFS_STATUS: begin
        rd_byte = {2'h0, status};
      end
      `TCX_OFS_MASK: begin
        rd_byte = {2'h0, mask};
      end
      default: begin
        // unmapped: zero data, error answer
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel: data registered on address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= `TCX_RST_BIT;
      s_axi_rdata <= '0;
      s_axi_rresp <= `TCX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {`TCX_BYTE_PAD, rd_byte};
      s_axi_rresp <= rd_hit ? `TCX_RESP_OKAY : `TCX_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // timer 0/1 overflow flags: overflow beats vectoring and writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf1 <= `TCX_RST_BIT;
      tf0 <= `TCX_RST_BIT;
    end else begin
      tf1 <= (wr_timer01_ext_interrupt_control ? w_data[`TCX_TC_TF1] : (tf1 && !vec_ack_timer1)) || timer1_ovf;
      tf0 <= (wr_timer01_ext_interrupt_control ? w_data[`TCX_TC_TF0] : (tf0 && !vec_ack_timer0)) || timer0_ovf;
    end
  end

  // timer 0/1 run bits and trigger types, software owned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tr1 <= `TCX_RST_BIT;
      tr0 <= `TCX_RST_BIT;
      it1 <= `TCX_RST_BIT;
      it0 <= `TCX_RST_BIT;
    end else if (wr_timer01_ext_interrupt_control) begin
      tr1 <= w_data[`TCX_TC_TR1];
      tr0 <= w_data[`TCX_TC_TR0];
      it1 <= w_data[`TCX_TC_IT1];
      it0 <= w_data[`TCX_TC_IT0];
    end
  end

  // timer 2 decode: baud mode blocks pin edges and the overflow flag
  assign baud = rclk || serial_tx_clock_select;
  assign ext_event = timer_two_ext_enable && capture_reload_pin_d && !capture_reload_pin && !baud;
  assign tf2_set = timer2_ovf && !baud;
  assign next_capture = cprl2 && !baud && ext_event;
  // reload on overflow or pin edge; baud forces overflow only
  assign next_reload = (!cprl2 || baud) && (timer2_ovf || ext_event);
  assign next_count = tr2 && (ct2 ? (cnt_d && !timer2_count_pin) : machine_cycle_tick);
  assign mode13 = (uart_mode == `TCX_UART_MODE1) || (uart_mode == `TCX_UART_MODE3);
  assign next_rx = (rclk && mode13) ? timer2_ovf : timer1_ovf;
  assign next_tx = (serial_tx_clock_select && mode13) ? timer2_ovf : timer1_ovf;

  // timer 2 flags: hardware only sets, software write clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf2 <= `TCX_RST_BIT;
      timer_two_external_flag <= `TCX_RST_BIT;
    end else begin
      tf2 <= (wr_t2 ? w_data[`TCX_T2_TF2] : tf2) || tf2_set;
      timer_two_external_flag <= (wr_t2 ? w_data[`TCX_T2_TIMER_TWO_EXTERNAL_FLAG] : timer_two_external_flag) || ext_event;
    end
  end

  // timer 2 configuration; run bit loads with the other fields on each write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rclk <= `TCX_RST_BIT;
      serial_tx_clock_select <= `TCX_RST_BIT;
      timer_two_ext_enable <= `TCX_RST_BIT;
      tr2 <= `TCX_RST_BIT;
      ct2 <= `TCX_RST_BIT;
      cprl2 <= `TCX_RST_BIT;
    end else if (wr_t2) begin
      rclk <= w_data[`TCX_T2_RCLK];
      serial_tx_clock_select <= w_data[`TCX_T2_SERIAL_TX_CLOCK_SELECT];
      timer_two_ext_enable <= w_data[`TCX_T2_EXEN];
      tr2 <= w_data[`TCX_T2_TR2];
      ct2 <= w_data[`TCX_T2_CT];
      cprl2 <= w_data[`TCX_T2_CPRL];
    end
  end

  // pin history for falling edge detection, idle high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reload_pin_d <= `TCX_PIN_IDLE;
      cnt_d <= `TCX_PIN_IDLE;
    end else begin
      capture_reload_pin_d <= capture_reload_pin;
      cnt_d <= timer2_count_pin;
    end
  end

  // registered timer 2 strobes and serial clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer2_capture <= `TCX_RST_BIT;
      timer2_reload <= `TCX_RST_BIT;
      timer2_count_tick <= `TCX_RST_BIT;
      serial_rx_clk <= `TCX_RST_BIT;
      serial_tx_clk <= `TCX_RST_BIT;
    end else begin
      timer2_capture <= next_capture;
      timer2_reload <= next_reload;
      timer2_count_tick <= next_count;
      serial_rx_clk <= next_rx;
      serial_tx_clk <= next_tx;
    end
  end

  // event pulses for the sticky status
  always_comb begin
    evt = `TCX_RST_EVT;
    evt[`TCX_EV_TF0] = timer0_ovf;
    evt[`TCX_EV_TF1] = timer1_ovf;
    evt[`TCX_EV_IE0] = ext_bus.set_evt[0];
    evt[`TCX_EV_IE1] = ext_bus.set_evt[1];
    evt[`TCX_EV_TF2] = tf2_set;
    evt[`TCX_EV_TIMER_TWO_EXTERNAL_FLAG] = ext_event;
  end

  // sticky status with write-one-to-clear, mask, level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= `TCX_RST_EVT;
      mask <= `TCX_RST_EVT;
      irq <= `TCX_RST_BIT;
    end else begin
      // a new event beats a clear in the same cycle
      status <= (status & ~(wr_status ? w_data[`TCX_EVT_W-1:0] : `TCX_RST_EVT)) | evt;
      if (wr_mask) begin
        mask <= w_data[`TCX_EVT_W-1:0];
      end
      irq <= |(status & mask);
    end
  end

  // outputs straight from control and flag registers
  assign timer0_count_en = tr0;
  assign timer1_count_en = tr1;
  assign timer2_count_source = ct2;
  assign timer0_irq_req = tf0;
  assign timer1_irq_req = tf1;
  assign ext_int0_irq_req = ext_bus.flag[0];
  assign ext_int1_irq_req = ext_bus.flag[1];
  assign timer2_irq_req = tf2 || timer_two_external_flag;

  a_tf1_on_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    timer1_ovf |=> (tf1 && timer1_irq_req)) else $error("timer 1 overflow flag not set");
  a_tf0_vec_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (tf0 && vec_ack_timer0 && !timer0_ovf && !wr_timer01_ext_interrupt_control) |=> !tf0)
    else $error("timer 0 flag not cleared by vectoring");
  a_run_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_timer01_ext_interrupt_control && !w_data[`TCX_TC_TR1]) |=> !timer1_count_en ##1 (!timer1_count_en || wr_timer01_ext_interrupt_control))
    else $error("timer 1 still enabled after run bit cleared");
  a_tf2_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (tf2 && !wr_t2) |=> tf2) else $error("timer 2 overflow flag lost without write");
  a_tf2_baud_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (baud && !tf2 && !wr_t2) |=> !tf2) else $error("timer 2 flag set in baud mode");
  a_timer_two_external_flag_on_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (timer_two_ext_enable && !baud && $fell(capture_reload_pin)) |=> (timer_two_external_flag && timer2_irq_req))
    else $error("pin edge did not set timer 2 external flag");
  a_pin_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (!timer_two_ext_enable && !timer2_ovf) |=> (!timer2_capture && !timer2_reload))
    else $error("pin acted while external enable is zero");
  a_cap_not_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_event && cprl2) |=> (timer2_capture && !timer2_reload))
    else $error("capture mode edge did not capture alone");
  a_baud_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    baud |=> (!timer2_capture && (timer2_reload == $past(timer2_ovf))))
    else $error("baud mode reload not tied to overflow");
  a_rx_clk_src: assert property (@(posedge aclk) disable iff (!aresetn)
    (rclk && mode13) |=> (serial_rx_clk == $past(timer2_ovf)))
    else $error("receive clock not from timer 2");
  a_tx_clk_src: assert property (@(posedge aclk) disable iff (!aresetn)
    !serial_tx_clock_select |=> (serial_tx_clk == $past(timer1_ovf)))
    else $error("transmit clock not from timer 1");
  a_count_source: assert property (@(posedge aclk) disable iff (!aresetn)
    (tr2 && !ct2 && machine_cycle_tick) |=> timer2_count_tick)
    else $error("internal count tick missed");
endmodule

// File: tb/tcx_core_model.sv
`timescale 1ns/1ps
module tcx_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ack_en, // core may vector to routines
  input wire logic [3:0] irq_req, // ext1, ext0, timer1, timer0 requests
  input wire logic timer2_irq_req, // timer 2 request level
  output logic [3:0] vec_ack // one-cycle vectoring pulses
);
  logic t2_seen; // timer 2 request seen last cycle
  logic [7:0] t2_entries; // timer 2 routine entries
  // pulse every other cycle while a request stays high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_ack <= 4'h0;
    end else begin
      vec_ack <= {4{ack_en}} & irq_req & ~vec_ack;
    end
  end
  // timer 2 gets no hardware clear, so only the routine's write ends it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t2_seen <= 1'h0;
      t2_entries <= 8'h00;
    end else begin
      t2_seen <= timer2_irq_req;
      t2_entries <= t2_entries + 8'(ack_en & timer2_irq_req & ~t2_seen);
    end
  end
endmodule

// File: tb/timer_control_and_ext_int_flags_tb_top.sv
`timescale 1ns/1ps
`include "tcx_consts.svh"
module timer_control_and_ext_int_flags_tb_top;
  import tcx_pkg::*;
  logic aclk = 1'h0; // bus clock
  logic aresetn = 1'h0; // reset, low active
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // bus addresses
  logic [31:0] wdata = 32'h0; // write data
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic t0_ovf = 1'h0, t1_ovf = 1'h0, t2_ovf = 1'h0, mc_tick = 1'h0; // datapath pulses
  logic cnt_pin = 1'h1, cr_pin = 1'h1; // external timer 2 pins, idle high
  logic [1:0] ext_pin_n = 2'h3; // external interrupt pins, idle high
  logic ack_en = 1'h0; // lets the core model vector
  tcx_uart_mode_t uart_mode = 2'h0; // serial mode
  wire [3:0] irq_req, vec_ack; // ext1, ext0, timer1, timer0
  logic rx_clk, tx_clk, t0_en, t1_en, t2_tick, t2_src, t2_cap, t2_rel, t2_irq, irq;
  int n_errors = 0, n_checks = 0;
  logic cap_seen, rel_seen, sel13; // window results, serial mode 1/3 select
  logic [7:0] cfg[5] = '{8'h09, 8'h08, 8'h01, 8'h00, 8'h38}; // timer 2 setups
  logic [2:0] expc[5] = '{3'h5, 3'h3, 3'h0, 3'h0, 3'h0}; // capture, reload, ext flag
  int i, m, s;
  // free-running bus clock
  always #12.5 aclk = ~aclk;
  tcx_timer_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_ovf(t0_ovf), .timer1_ovf(t1_ovf), .timer2_ovf(t2_ovf),
    .machine_cycle_tick(mc_tick), .timer2_count_pin(cnt_pin), .capture_reload_pin(cr_pin),
    .ext_int0_pin_n(ext_pin_n[0]), .ext_int1_pin_n(ext_pin_n[1]),
    .vec_ack_timer0(vec_ack[0]), .vec_ack_timer1(vec_ack[1]), .vec_ack_ext0(vec_ack[2]),
    .vec_ack_ext1(vec_ack[3]), .uart_mode(uart_mode), .serial_rx_clk(rx_clk),
    .serial_tx_clk(tx_clk), .timer0_count_en(t0_en), .timer1_count_en(t1_en),
    .timer2_count_tick(t2_tick), .timer2_count_source(t2_src), .timer2_capture(t2_cap),
    .timer2_reload(t2_rel), .timer0_irq_req(irq_req[0]), .timer1_irq_req(irq_req[1]),
    .ext_int0_irq_req(irq_req[2]), .ext_int1_irq_req(irq_req[3]),
    .timer2_irq_req(t2_irq), .irq(irq));
  tcx_core_model i_core (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en),
    .irq_req(irq_req), .timer2_irq_req(t2_irq), .vec_ack(vec_ack));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write, both halves offered together, response checked
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    chk(32'({bvalid, bresp}), 32'({1'h1, er}));
    bready <= 1'h0;
  endtask
  // one read, data and response checked
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    chk(32'({rvalid, rresp}), 32'({1'h1, er}));
    chk(rdata, ed);
    rready <= 1'h0;
  endtask
  // one-cycle high pulse on 0 t0_ovf, 1 t1_ovf, 2 t2_ovf, 3 mc_tick
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: t0_ovf <= 1'h1;
      1: t1_ovf <= 1'h1;
      2: t2_ovf <= 1'h1;
      default: mc_tick <= 1'h1;
    endcase
    @(posedge aclk);
    t0_ovf <= 1'h0;
    t1_ovf <= 1'h0;
    t2_ovf <= 1'h0;
    mc_tick <= 1'h0;
  endtask
  // falling edge on the capture/reload pin, strobes gathered over a window
  task automatic fall_cr();
    cap_seen = 1'h0;
    rel_seen = 1'h0;
    @(posedge aclk);
    cr_pin <= 1'h0;
    repeat (3) begin
      @(posedge aclk);
      #1;
      cap_seen = cap_seen | t2_cap;
      rel_seen = rel_seen | t2_rel;
    end
    @(posedge aclk);
    cr_pin <= 1'h1;
  endtask
  // let the core vector, then expect the flag gone
  task automatic vector_clears(input int b);
    ack_en <= 1'h1;
    repeat (4) @(posedge aclk);
    chk(32'(irq_req[b]), 32'h0);
    ack_en <= 1'h0;
  endtask
  // verdict
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #500000;
    n_errors++;
    results();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, 32'h0, `TCX_RESP_OKAY);
    axi_read(8'h10, 32'h0, `TCX_RESP_SLVERR);
    axi_write(8'h10, 32'hff, `TCX_RESP_SLVERR);
    axi_write(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, 32'h50, `TCX_RESP_OKAY);
    #1 chk(32'({t1_en, t0_en}), 32'h3);
    axi_write(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, 32'h10, `TCX_RESP_OKAY);
    #1 chk(32'({t1_en, t0_en}), 32'h1);
    axi_write(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, 32'h0, `TCX_RESP_OKAY);
    // overflow flags set, then cleared by vectoring
    for (i = 0; i < 2; i++) begin
      pulse(i);
      #1 chk(32'(irq_req[i]), 32'h1);
      axi_read(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, (i == 0) ? 32'h20 : 32'h80, `TCX_RESP_OKAY);
      vector_clears(i);
    end
    // sticky status, mask and the interrupt line
    axi_read(`TCX_OFS_STATUS, 32'h03, `TCX_RESP_OKAY);
    axi_write(`TCX_OFS_MASK, 32'h02, `TCX_RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1 chk(32'(irq), 32'h1);
    axi_write(`TCX_OFS_STATUS, 32'h02, `TCX_RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1 chk(32'(irq), 32'h0);
    axi_read(`TCX_OFS_STATUS, 32'h01, `TCX_RESP_OKAY);
    axi_write(`TCX_OFS_MASK, 32'h00, `TCX_RESP_OKAY);
    // falling-edge mode: flag outlives the pin pulse
    axi_write(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, 32'h05, `TCX_RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      @(posedge aclk);
      ext_pin_n[i] <= 1'h0;
      repeat (3) @(posedge aclk);
      ext_pin_n[i] <= 1'h1;
      repeat (3) @(posedge aclk);
      #1 chk(32'(irq_req[2 + i]), 32'h1);
      vector_clears(2 + i);
    end
    // low-level mode: flag follows the pin
    axi_write(`TCX_OFS_TIMER01_EXT_INTERRUPT_CONTROL, 32'h00, `TCX_RESP_OKAY);
    @(posedge aclk);
    ext_pin_n[0] <= 1'h0;
    repeat (3) @(posedge aclk);
    #1 chk(32'(irq_req[2]), 32'h1);
    @(posedge aclk);
    ext_pin_n[0] <= 1'h1;
    repeat (3) @(posedge aclk);
    #1 chk(32'(irq_req[2]), 32'h0);
    // serial clock sources and overflow flag suppression, all modes
    for (m = 0; m < 4; m++) begin
      for (s = 0; s < 4; s++) begin
        axi_write(`TCX_OFS_TIMER_TWO_CONTROL, 32'(s * 16), `TCX_RESP_OKAY);
        uart_mode <= 2'(m);
        sel13 = (m == 1 || m == 3);
        pulse(2);
        #1 chk(32'({rx_clk, tx_clk}), 32'({sel13 & s[1], sel13 & s[0]}));
        pulse(1);
        #1 chk(32'({rx_clk, tx_clk}), 32'({~(sel13 & s[1]), ~(sel13 & s[0])}));
        axi_read(`TCX_OFS_TIMER_TWO_CONTROL, 32'(s * 16) | ((s == 0) ? 32'h80 : 32'h0), `TCX_RESP_OKAY);
        chk(32'(t2_irq), 32'(s == 0));
      end
    end
    // capture, reload and the external flag per setup
    for (i = 0; i < 5; i++) begin
      axi_write(`TCX_OFS_TIMER_TWO_CONTROL, 32'(cfg[i]), `TCX_RESP_OKAY);
      fall_cr();
      chk(32'({cap_seen, rel_seen}), 32'(expc[i][2:1]));
      axi_read(`TCX_OFS_TIMER_TWO_CONTROL, 32'(cfg[i] | {expc[i][0], 6'h00}), `TCX_RESP_OKAY);
    end
    pulse(2);
    #1 chk(32'(t2_rel), 32'h1);
    // timer 2 run bit and count source
    axi_write(`TCX_OFS_TIMER_TWO_CONTROL, 32'h04, `TCX_RESP_OKAY);
    pulse(3);
    #1 chk(32'({t2_tick, t2_src}), 32'h2);
    axi_write(`TCX_OFS_TIMER_TWO_CONTROL, 32'h06, `TCX_RESP_OKAY);
    pulse(3);
    #1 chk(32'({t2_tick, t2_src}), 32'h1);
    results();
  end
endmodule
